// ==== tb/drsg_guard_tb.sv ====
// Self-checking bench for the drive reset, stop and write guard.
// Assumes the unit model and a shortened disconnect window of LIM cycles.
`timescale 1ns/10ps
`default_nettype none
module drsg_guard_tb;
  import drsg_pkg::*;
  localparam int unsigned LIM = 20;
  logic       sys_clk, rst_n, reg_wr, reg_rd, run, trip, um, em, coast;
  logic       wreq, link, jog, present, skey, rkey, mkey, forward_run_key, reverse_run_key, gset;
  drsg_src_t  src;
  logic       w_ok, fault, ps, decel, shut, clr, inh;
  logic [3:0] reg_addr, pins;
  logic [7:0] reg_wdata, reg_rdata, rv, sel, prot;
  int         failures, total_checks, n_clr, n_off, seed, i, c, o;

  drsg_guard #(.DISC_LIMIT(LIM)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_reset_signal(pins[0]),
    .forward_start_signal(forward_run_key), .reverse_start_signal(reverse_run_key),
    .unit_present(present), .unit_reset_key(rkey), .unit_stop_key(skey),
    .panel_stop_key(pins[1]), .unit_mode_key(mkey),
    .panel_mode_key(pins[2]), .comm_reset_req(pins[3]),
    .link_via_unit_connector(link), .operator_unit_mode(um),
    .external_operation_mode(em), .unit_jog_active(jog),
    .drive_running(run), .drive_tripped(trip), .coast_selected(coast),
    .command_source_select(src), .param_write_req(wreq),
    .param_is_guard_setting(gset), .param_write_ok(w_ok),
    .operator_disconnect_fault(fault), .panel_stop_state(ps),
    .decel_stop(decel), .output_shutoff(shut),
    .clear_accumulators(clr), .restart_inhibit(inh));

  drsg_op_model u_op (
    .sys_clk(sys_clk), .unit_present(present), .unit_stop_key(skey),
    .unit_reset_key(rkey), .unit_mode_key(mkey),
    .forward_start_signal(forward_run_key), .reverse_start_signal(reverse_run_key));

  // Free-running 25 MHz system clock.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // One-cycle pulses are counted so tests need not hit their exact cycle.
  always @(posedge sys_clk) begin
    if (clr === 1'b1) n_clr++;
    if (shut === 1'b1) n_off++;
  end

  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Register write: one strobe cycle, then the strobe drops.
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Register read: data stand from the cycle after the strobe until the next read.
  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd

  // Pin 0 reset, 1 panel stop, 2 panel mode, 3 link reset request.
  task tog(input int k);
    repeat (2) begin
      @(posedge sys_clk);
      pins[k] <= !pins[k];
      repeat (4) @(posedge sys_clk);
    end
  endtask : tog

  // Source 4 is the unit reset key; compares pulse counts afterwards.
  task rst_ev(input int k, input int dc, input int doff);
    c = n_clr;
    o = n_off;
    if (k < 4) tog(k);
    else u_op.press(1);
    repeat (4) @(posedge sys_clk);
    chk("clear pulses", 8'(n_clr - c), 8'(dc));
    chk("shutoff pulses", 8'(n_off - o), 8'(doff));
  endtask : rst_ev

  function automatic logic sel_ok(input logic [7:0] s);
    return s <= SELECT_LOWER_MAX || (s >= SELECT_UPPER && s <= SELECT_UPPER_MAX);
  endfunction : sel_ok

  function automatic logic ok_exp(input logic [7:0] p, input logic u,
                                  input logic r);
    return p == PROTECT_ALWAYS || (p == PROTECT_STOPPED && u && !r);
  endfunction : ok_exp

  task tally_and_finish;
    $display("Checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // The run needs well under a thousand cycles; a hang is cut off well after.
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    tally_and_finish;
  end

  initial begin
    {rst_n, reg_wr, reg_rd, run, trip, um, em, coast, wreq, link, jog,
     gset} = '0;
    src          = DRSG_SRC_NONE;
    reg_addr     = 4'h0;
    reg_wdata    = 8'h00;
    pins         = 4'h0;
    failures     = 0;
    total_checks = 0;
    n_clr        = 0;
    n_off        = 0;
    seed         = 32'hA6EC;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ADDR_SELECT);
    chk("select", rv, SELECT_RESET);
    rd(ADDR_PROTECT);
    chk("protect", rv, PROTECT_RESET);
    rd(4'hF);
    chk("unmapped", rv, 8'h00);
    wr(ADDR_SELECT, 8'h02);
    rd(ADDR_SELECT);
    chk("locked select", rv, SELECT_RESET);
    wr(ADDR_DISPLAY, 8'h00);
    sel = SELECT_RESET;
    // Random settings; only listed values may stick.
    for (i = 0; i < 16; i++) begin
      rv = (i == 0) ? 8'h04 : 8'($random(seed)) & 8'h1F;
      wr(ADDR_SELECT, rv);
      if (sel_ok(rv)) sel = rv;
      rd(ADDR_SELECT);
      chk("select", rv, sel);
    end
    // Protect values 0..3 against random mode and run; 3 is refused.
    prot = PROTECT_RESET;
    wreq <= 1'b1;
    for (i = 0; i < 12; i++) begin
      wr(ADDR_PROTECT, 8'(i % 4));
      if (i % 4 < 3) prot = 8'(i % 4);
      {gset, um, run} <= 3'($random(seed));
      rd(ADDR_PROTECT);
      chk("protect", rv, prot);
      chk("write ok", {7'h0, w_ok},
          {7'h0, ok_exp(prot, um, run) || gset});
    end
    gset <= 1'b0;
    wr(ADDR_PROTECT, PROTECT_NEVER);
    wr(ADDR_CMD, 8'h01);
    wr(ADDR_SELECT, 8'h10);
    rd(ADDR_PROTECT);
    chk("protect after clear", rv, PROTECT_NEVER);
    rd(ADDR_SELECT);
    chk("select while locked", rv, 8'h10);
    wr(ADDR_PROTECT, PROTECT_STOPPED);
    wr(ADDR_CMD, 8'h02);
    rd(ADDR_DISPLAY);
    chk("display after clear", rv, DISPLAY_RESET);
    rd(ADDR_SELECT);
    chk("select after clear", rv, 8'h10);
    $display("test registers done");
    // Detection on, unit never seen since reset.
    repeat (3 * LIM) @(posedge sys_clk);
    chk("fault never seen", {7'h0, fault}, 8'h00);
    u_op.plug(1'b1);
    link <= 1'b1;
    repeat (5) @(posedge sys_clk);
    u_op.plug(1'b0);
    repeat (3 * LIM) @(posedge sys_clk);
    chk("fault over link", {7'h0, fault}, 8'h00);
    // Two short gaps together exceed the window; each restarts the count.
    for (i = 0; i < 2; i++) begin
      u_op.plug(1'b1);
      link <= 1'b0;
      repeat (5) @(posedge sys_clk);
      u_op.plug(1'b0);
      repeat (LIM - 5) @(posedge sys_clk);
    end
    u_op.plug(1'b1);
    repeat (5) @(posedge sys_clk);
    chk("fault short gaps", {7'h0, fault}, 8'h00);
    u_op.plug(1'b0);
    repeat (LIM + 10) @(posedge sys_clk);
    chk("fault long gap", {7'h0, fault}, 8'h01);
    u_op.plug(1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    {um, em, run, jog} <= 4'hB;
    repeat (5) @(posedge sys_clk);
    u_op.plug(1'b0);
    repeat (3 * LIM) @(posedge sys_clk);
    chk("fault detect off", {7'h0, fault}, 8'h00);
    chk("jog removal", {7'h0, decel}, 8'h01);
    u_op.plug(1'b1);
    {um, em, run, jog} <= 4'h6;
    $display("test disconnect done");
    rst_ev(0, 1, 1);
    run <= 1'b0;
    rst_ev(3, 1, 0);
    rst_ev(4, 0, 0);
    trip <= 1'b1;
    rst_ev(4, 1, 0);
    wr(ADDR_DISPLAY, 8'h00);
    wr(ADDR_SELECT, 8'h0F);
    trip <= 1'b0;
    rst_ev(3, 0, 0);
    rst_ev(0, 0, 0);
    trip <= 1'b1;
    rst_ev(0, 1, 0);
    trip <= 1'b0;
    $display("test reset done");
    // Unit stop during external running, coasting selected.
    wr(ADDR_SELECT, SELECT_UPPER);
    coast <= 1'b1;
    run   <= 1'b1;
    u_op.starts(1'b1);
    u_op.press(0);
    chk("panel stop", {7'h0, ps}, 8'h01);
    chk("no fault", {7'h0, fault}, 8'h00);
    chk("decelerate", {7'h0, decel}, 8'h01);
    run <= 1'b0;
    tog(2);
    chk("other unit clear", {7'h0, inh}, 8'h01);
    u_op.press(2);
    chk("clear with start on", {7'h0, inh}, 8'h01);
    u_op.restart;
    chk("cleared by unit", {7'h0, ps}, 8'h00);
    run <= 1'b1;
    u_op.press(0);
    run <= 1'b0;
    u_op.starts(1'b0);
    tog(0);
    chk("cleared by reset", {7'h0, ps}, 8'h00);
    // Lower settings: no latched stop, key acts only in unit mode.
    wr(ADDR_SELECT, 8'h02);
    run <= 1'b1;
    u_op.press(0);
    chk("low external stop", {6'h0, decel, ps}, 8'h00);
    um <= 1'b1;
    em <= 1'b0;
    u_op.press(0);
    chk("low unit stop", {6'h0, decel, ps}, 8'h02);
    // Panel selected as source: a stop from the unit latches panel stop.
    src <= DRSG_SRC_PANEL;
    wr(ADDR_SELECT, SELECT_UPPER);
    u_op.press(0);
    chk("unselected stop", {7'h0, ps}, 8'h01);
    $display("test panel stop done");
    tally_and_finish;
  end
endmodule : drsg_guard_tb
`default_nettype wire

// ==== tb/drsg_op_model.sv ====
// Model of the detachable operator unit and the external start switches.
// Assumes the guard synchronises these pins; keys are held several cycles.
`timescale 1ns/10ps
`default_nettype none
module drsg_op_model (
  input  wire logic sys_clk,
  output logic      unit_present,
  output logic      unit_stop_key,
  output logic      unit_reset_key,
  output logic      unit_mode_key,
  output logic      forward_start_signal,
  output logic      reverse_start_signal
);
  logic [2:0] keys = 3'h0;
  logic       fit  = 1'b0;

  // A unit that is unplugged can press nothing, so its keys read low.
  assign unit_present   = fit;
  assign unit_stop_key  = keys[0] & fit;
  assign unit_reset_key = keys[1] & fit;
  assign unit_mode_key  = keys[2] & fit;

  // Reverse is never used here; forward alone exercises the handshake.
  initial begin
    forward_start_signal = 1'b0;
    reverse_start_signal = 1'b0;
  end

  // Plug or pull the unit just after a clock edge.
  task plug(input logic p);
    @(posedge sys_clk);
    fit <= p;
  endtask : plug

  task starts(input logic f);
    @(posedge sys_clk);
    forward_start_signal <= f;
  endtask : starts

  // Key 0 stop, 1 reset, 2 mode; held past the two-flop synchroniser.
  task press(input int k);
    if (k == 1 && forward_start_signal) starts(1'b0);
    repeat (2) begin
      @(posedge sys_clk);
      keys[k] <= !keys[k];
      repeat (4) @(posedge sys_clk);
    end
  endtask : press

  // Starts off, clear from this unit, then start again.
  task restart;
    starts(1'b0);
    press(2);
    starts(1'b1);
  endtask : restart
endmodule : drsg_op_model
`default_nettype wire

// ==== verilog/drsg_disc_timer.sv ====
// Continuous-absence timer for the detachable operator unit.
// Assumes a synchronised presence level on the system clock.
`timescale 1ns/10ps
`default_nettype none
module drsg_disc_timer #(
  parameter int unsigned LIMIT = 25000000
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic present,
  output logic      expired
);
  localparam int unsigned W = $clog2(LIMIT + 1);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  initial begin
    if (LIMIT < 2) $error("drsg_disc_timer: LIMIT too small");
  end

  // Presence or a disabled check restarts the count; saturate past the window.
  always_comb begin
    cnt_nxt = cnt_r;
    if (!enable || present) begin
      cnt_nxt = '0;
    end else if (cnt_r <= W'(LIMIT)) begin
      cnt_nxt = cnt_r + W'(1);
    end
  end

  // Registers only.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Strictly more than the window of continuous absence.
  assign expired = (cnt_r > W'(LIMIT));

  a_timer_restart : assert property (@(posedge sys_clk) disable iff (!rst_n)
    present |=> cnt_r == '0)
    else $error("timer not restarted on presence");
endmodule : drsg_disc_timer
`default_nettype wire

// ==== verilog/drsg_guard.sv ====
// Supervisory guard: reset acceptance, unit disconnect, panel stop, write lock.
// Assumes pins arrive asynchronously and software uses the plain register port.
`timescale 1ns/10ps
`default_nettype none
module drsg_guard
  import drsg_pkg::*;
#(
  parameter int unsigned DISC_LIMIT = drsg_pkg::DISC_CYCLES
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire logic [3:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [7:0]      reg_rdata,
  input  wire logic            external_reset_signal,
  input  wire logic            forward_start_signal,
  input  wire logic            reverse_start_signal,
  input  wire logic            unit_present,
  input  wire logic            unit_reset_key,
  input  wire logic            unit_stop_key,
  input  wire logic            panel_stop_key,
  input  wire logic            unit_mode_key,
  input  wire logic            panel_mode_key,
  input  wire logic            comm_reset_req,
  input  wire logic            link_via_unit_connector,
  input  wire logic            operator_unit_mode,
  input  wire logic            external_operation_mode,
  input  wire logic            unit_jog_active,
  input  wire logic            drive_running,
  input  wire logic            drive_tripped,
  input  wire logic            coast_selected,
  input  wire drsg_pkg::drsg_src_t command_source_select,
  input  wire logic            param_write_req,
  input  wire logic            param_is_guard_setting,
  output logic                 param_write_ok,
  output logic                 operator_disconnect_fault,
  output logic                 panel_stop_state,
  output logic                 decel_stop,
  output logic                 output_shutoff,
  output logic                 clear_accumulators,
  output logic                 restart_inhibit
);
  localparam int unsigned IDW = 2;

  initial begin
    if (DISC_LIMIT < 2) $error("drsg_guard: DISC_LIMIT too small");
  end

  // Pins cross from outside; two flops before any logic reads them.
  localparam int unsigned NSY = 10;
  logic [NSY-1:0] pin_raw;
  logic [NSY-1:0] sy1_r;
  logic [NSY-1:0] sy2_r;
  assign pin_raw = {external_reset_signal, forward_start_signal,
                    reverse_start_signal, unit_present, unit_reset_key,
                    unit_stop_key, panel_stop_key, unit_mode_key,
                    panel_mode_key, comm_reset_req};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sy1_r <= '0;
      sy2_r <= '0;
    end else begin
      sy1_r <= pin_raw;
      sy2_r <= sy1_r;
    end
  end

  logic ext_res_s, fwd_s, rev_s, present_s, ureset_s;
  logic ustop_s, pstop_s, umode_s, pmode_s, cres_s;
  assign {ext_res_s, fwd_s, rev_s, present_s, ureset_s,
          ustop_s, pstop_s, umode_s, pmode_s, cres_s} = sy2_r;

  // Edge detection on the synchronised keys, read only after the second flop.
  logic [NSY-1:0] prev_r;
  logic [NSY-1:0] rise;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prev_r <= '0;
    end else begin
      prev_r <= sy2_r;
    end
  end
  assign rise = sy2_r & ~prev_r;

  logic ext_res_p, ureset_p, ustop_p, pstop_p, umode_p, pmode_p, cres_p;
  assign ext_res_p = rise[9];
  assign ureset_p  = rise[5];
  assign ustop_p   = rise[4];
  assign pstop_p   = rise[3];
  assign umode_p   = rise[2];
  assign pmode_p   = rise[1];
  assign cres_p    = rise[0];

  // Decoding helpers for the select value.
  function automatic logic sel_legal(input logic [7:0] v);
    return (v <= SELECT_LOWER_MAX) ||
           (v >= SELECT_UPPER && v <= SELECT_UPPER_MAX);
  endfunction : sel_legal

  function automatic logic sel_trip_only(input logic [7:0] v);
    return v[BIT_RESET_TRIP];
  endfunction : sel_trip_only

  function automatic logic sel_disc_on(input logic [7:0] v);
    // Lower group detects on 2 and 3, upper group on 16 and 17.
    return v[BIT_DISC_TRIP] ^ sel_upper(v);
  endfunction : sel_disc_on

  function automatic logic sel_upper(input logic [7:0] v);
    return v >= SELECT_UPPER;
  endfunction : sel_upper

  // Register file state.
  logic [7:0] select_r, select_nxt;
  logic [7:0] protect_r, protect_nxt;
  logic [7:0] display_r, display_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       pclr_done_r, pclr_done_nxt;

  // Parameter write permission for the wider parameter store.
  logic write_perm;
  always_comb begin
    case (protect_r)
      PROTECT_STOPPED: write_perm = !drive_running && operator_unit_mode;
      PROTECT_NEVER:   write_perm = 1'b0;
      PROTECT_ALWAYS:  write_perm = 1'b1;
      default:         write_perm = 1'b0;
    endcase
  end
  assign param_write_ok = param_write_req &&
                          (write_perm || param_is_guard_setting);

  // Software writes; guard settings gated by the display selection only.
  logic guard_open;
  assign guard_open = (display_r == 8'h00);

  always_comb begin
    select_nxt    = select_r;
    protect_nxt   = protect_r;
    display_nxt   = display_r;
    pclr_done_nxt = 1'b0;
    rdata_nxt     = rdata_r;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_SELECT: begin
          // Writable whatever the run state or write lock.
          if (guard_open && sel_legal(reg_wdata)) begin
            select_nxt = reg_wdata;
          end
        end
        ADDR_PROTECT: begin
          if (guard_open && reg_wdata <= PROTECT_ALWAYS) begin
            protect_nxt = reg_wdata;
          end
        end
        ADDR_DISPLAY: display_nxt = reg_wdata;
        ADDR_CMD: begin
          // Clears never touch the select value, and are barred under lock.
          if ((reg_wdata[CMD_PARAM_CLEAR] || reg_wdata[CMD_ALL_CLEAR]) &&
              protect_r != PROTECT_NEVER) begin
            protect_nxt   = PROTECT_RESET;
            display_nxt   = DISPLAY_RESET;
            pclr_done_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_SELECT:  rdata_nxt = select_r;
        ADDR_PROTECT: rdata_nxt = protect_r;
        ADDR_DISPLAY: rdata_nxt = display_r;
        ADDR_STATUS:  rdata_nxt = {3'h0, decel_stop, restart_inhibit,
                                   panel_stop_state,
                                   operator_disconnect_fault, pclr_done_r};
        default:      rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      select_r    <= SELECT_RESET;
      protect_r   <= PROTECT_RESET;
      display_r   <= DISPLAY_RESET;
      rdata_r     <= 8'h00;
      pclr_done_r <= 1'b0;
    end else begin
      select_r    <= select_nxt;
      protect_r   <= protect_nxt;
      display_r   <= display_nxt;
      rdata_r     <= rdata_nxt;
      pclr_done_r <= pclr_done_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  // Reset acceptance. The unit key always needs a trip.
  logic res_req, res_ok, unit_res_ok;
  assign res_req     = ext_res_p || cres_p;
  assign res_ok      = res_req &&
                       (!sel_trip_only(select_r) || drive_tripped);
  assign unit_res_ok = ureset_p && drive_tripped;

  // Disconnect watch: armed only once the unit has been seen.
  logic seen_r, seen_nxt, fault_r, fault_nxt, disc_en, expired;
  assign disc_en = sel_disc_on(select_r) && seen_r &&
                   !link_via_unit_connector;

  drsg_disc_timer #(
    .LIMIT (DISC_LIMIT)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .enable  (disc_en),
    .present (present_s),
    .expired (expired)
  );

  // Panel stop state and its clearing sources.
  logic ps_r, ps_nxt;
  drsg_src_t ps_src_r, ps_src_nxt;
  logic stop_any, stop_src_unit, enter_ps, stop_cmd;
  logic clr_key, clr_ok;
  drsg_src_t selected_src;

  // Default source selection gives the detachable unit priority.
  assign selected_src = (command_source_select == DRSG_SRC_NONE) ?
                        (present_s ? DRSG_SRC_UNIT : DRSG_SRC_PANEL) :
                        command_source_select;

  always_comb begin
    stop_any      = ustop_p || pstop_p;
    stop_src_unit = ustop_p;
    enter_ps      = 1'b0;
    stop_cmd      = 1'b0;
    if (stop_any) begin
      if (operator_unit_mode) begin
        stop_cmd = 1'b1;
        if (sel_upper(select_r) &&
            ((stop_src_unit && selected_src != DRSG_SRC_UNIT) ||
             (!stop_src_unit && selected_src != DRSG_SRC_PANEL) ||
             (pstop_p && link_via_unit_connector))) begin
          enter_ps = 1'b1;
        end
      end else if (sel_upper(select_r)) begin
        stop_cmd = 1'b1;
        enter_ps = 1'b1;
      end
    end
  end

  // Clear only from the issuing unit, with starts released and motor halted.
  assign clr_key = (ps_src_r == DRSG_SRC_UNIT) ? umode_p : pmode_p;
  assign clr_ok  = ps_r && clr_key && !drive_running &&
                   !fwd_s && !rev_s;

  always_comb begin
    ps_nxt     = ps_r;
    ps_src_nxt = ps_src_r;
    seen_nxt   = seen_r || present_s;
    fault_nxt  = fault_r;
    if (clr_ok) begin
      ps_nxt     = 1'b0;
      ps_src_nxt = DRSG_SRC_NONE;
    end
    if (res_ok || unit_res_ok) begin
      ps_nxt     = 1'b0;
      ps_src_nxt = DRSG_SRC_NONE;
      fault_nxt  = 1'b0;
    end
    // A new stop wins over a clear in the same cycle.
    if (enter_ps) begin
      ps_nxt     = 1'b1;
      ps_src_nxt = stop_src_unit ? DRSG_SRC_UNIT : DRSG_SRC_PANEL;
    end
    if (disc_en && expired) begin
      fault_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ps_r     <= 1'b0;
      ps_src_r <= DRSG_SRC_NONE;
      seen_r   <= 1'b0;
      fault_r  <= 1'b0;
    end else begin
      ps_r     <= ps_nxt;
      ps_src_r <= ps_src_nxt;
      seen_r   <= seen_nxt;
      fault_r  <= fault_nxt;
    end
  end

  // Drive commands, registered so they stand clean of key glitches.
  logic decel_r, decel_nxt, shut_r, shut_nxt, clr_acc_r, clr_acc_nxt;
  always_comb begin
    shut_nxt    = (res_ok || unit_res_ok) && drive_running;
    clr_acc_nxt = res_ok || unit_res_ok;
    decel_nxt   = decel_r && drive_running;
    // Controlled stop regardless of the coast choice.
    if (stop_cmd && drive_running) begin
      decel_nxt = 1'b1;
    end
    if (!sel_disc_on(select_r) && unit_jog_active && !present_s &&
        drive_running) begin
      decel_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      decel_r   <= 1'b0;
      shut_r    <= 1'b0;
      clr_acc_r <= 1'b0;
    end else begin
      decel_r   <= decel_nxt;
      shut_r    <= shut_nxt;
      clr_acc_r <= clr_acc_nxt;
    end
  end

  // The operator keeps starts off before a reset; we only block restarts.
  assign operator_disconnect_fault = fault_r;
  assign panel_stop_state          = ps_r;
  assign restart_inhibit           = ps_r;
  assign decel_stop                = decel_r;
  assign output_shutoff            = shut_r;
  assign clear_accumulators        = clr_acc_r;

  a_reset_trip_only : assert property (@(posedge sys_clk) disable iff (!rst_n)
    (res_req && !ureset_p && sel_trip_only(select_r) && !drive_tripped)
      |=> !clear_accumulators)
    else $error("reset accepted while not tripped");
  a_reset_shutoff : assert property (@(posedge sys_clk) disable iff (!rst_n)
    (res_ok && drive_running) |=> output_shutoff)
    else $error("running reset did not cut output");
  a_reset_clears_acc : assert property (@(posedge sys_clk) disable iff (!rst_n)
    res_ok |=> clear_accumulators)
    else $error("accumulators not cleared");
  a_unit_key_trip : assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ureset_p && !drive_tripped && !res_req) |=> !clear_accumulators)
    else $error("unit reset key acted untripped");
  a_no_disc_fault : assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!sel_disc_on(select_r) && !fault_r) |=> !operator_disconnect_fault)
    else $error("fault with detection off");
  a_ps_no_fault : assert property (@(posedge sys_clk) disable iff (!rst_n)
    (enter_ps && !fault_r && !(disc_en && expired)) |=> 
      panel_stop_state && !operator_disconnect_fault)
    else $error("panel stop raised fault");
  sequence s_ps_held;
    panel_stop_state && !clr_ok && !res_ok && !unit_res_ok;
  endsequence
  a_ps_held : assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ps_held |=> panel_stop_state)
    else $error("panel stop dropped without clear");
  a_lock_blocks : assert property (@(posedge sys_clk) disable iff (!rst_n)
    (protect_r == PROTECT_NEVER && !param_is_guard_setting)
      |-> !param_write_ok)
    else $error("write allowed under lock");
  a_select_legal : assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 sel_legal(select_r))
    else $error("illegal select value stored");
endmodule : drsg_guard
`default_nettype wire

// ==== verilog/drsg_pkg.sv ====
// Constants and types for the drive reset, stop and write guard.
// Assumes a single 25 MHz clock and a plain register port.
package drsg_pkg;
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned DISC_TIME_MS    = 1000;
  localparam int unsigned DISC_CYCLES     = CLK_HZ / 1000 * DISC_TIME_MS;
  localparam logic [3:0] ADDR_SELECT      = 4'h0;
  localparam logic [3:0] ADDR_PROTECT     = 4'h1;
  localparam logic [3:0] ADDR_DISPLAY     = 4'h2;
  localparam logic [3:0] ADDR_STATUS      = 4'h3;
  localparam logic [3:0] ADDR_CMD         = 4'h4;
  localparam logic [7:0] SELECT_RESET     = 8'h0E;
  localparam logic [7:0] PROTECT_RESET    = 8'h00;
  localparam logic [7:0] DISPLAY_RESET    = 8'h01;
  localparam logic [7:0] PROTECT_STOPPED  = 8'h00;
  localparam logic [7:0] PROTECT_NEVER    = 8'h01;
  localparam logic [7:0] PROTECT_ALWAYS   = 8'h02;
  localparam logic [7:0] SELECT_UPPER     = 8'h0E;
  localparam logic [7:0] SELECT_LOWER_MAX = 8'h03;
  localparam logic [7:0] SELECT_UPPER_MAX = 8'h11;
  localparam int unsigned BIT_RESET_TRIP  = 0;
  localparam int unsigned BIT_DISC_TRIP   = 1;
  localparam int unsigned CMD_PARAM_CLEAR = 0;
  localparam int unsigned CMD_ALL_CLEAR   = 1;
  typedef enum logic [1:0] {
    DRSG_SRC_NONE,
    DRSG_SRC_PANEL,
    DRSG_SRC_UNIT
  } drsg_src_t;
endpackage : drsg_pkg
